/* File: rtl/low_power_clock_stop_wake.sv */
// Purpose: Core-side stop, sleep and wake sequencing of a static processor
// Assumes: Outside glue gates the clock, polls the interrupt lines and restarts
// Notes:   Pins are asynchronous and pass two flip-flops before use
module low_power_clock_stop_wake
  import lp_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Instruction unit
  input  wire logic             stop_exec,
  input  wire logic [SR_W-1:0]  stop_operand,
  // Pins from the glue logic
  input  wire logic [IPL_W-1:0] buffered_interrupt_priority,
  input  wire logic             clock_hold,
  input  wire logic             restart_req,
  input  wire logic             bus_request_in,
  // Core state
  output logic      [SR_W-1:0]  status_register,
  output logic      [IPL_W-1:0] wake_level,
  output logic                  core_clk_en,
  output logic                  stopped,
  output logic                  low_power,
  output logic                  exec_resume
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage one feeds stage two only; every decision reads stage two
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  wire  [SYNC_W-1:0] pins_raw;

  assign pins_raw = {buffered_interrupt_priority, clock_hold, restart_req, bus_request_in};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire [IPL_W-1:0] ipl_s;
  wire             hold_s;
  wire             restart_s;
  wire             busreq_s;

  assign ipl_s     = sync2_reg[SYNC_W-1:3];
  assign hold_s    = sync2_reg[2];
  assign restart_s = sync2_reg[1];
  assign busreq_s  = sync2_reg[0];

  // ----------------------------------------------------------------
  // Wake comparator
  // ----------------------------------------------------------------
  logic [SR_W-1:0] sr_reg;
  wake_if          wk ();
  wire             hit;

  assign wk.level = ipl_s;
  assign wk.mask  = sr_reg[MASK_LSB+IPL_W-1:MASK_LSB];
  assign hit      = wk.hit;

  mask_compare u_cmp (
    .w (wk.cmp)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  lp_state_t state_reg;
  lp_state_t state_next;

  wire in_run;
  wire in_halt;
  wire in_sleep;
  wire in_wake;
  wire take_stop;
  wire take_wake;
  wire go_sleep;
  wire go_run;

  assign in_run    = (state_reg == ST_RUN);
  assign in_halt   = (state_reg == ST_HALT);
  assign in_sleep  = (state_reg == ST_SLEEP);
  assign in_wake   = (state_reg == ST_WAKE);
  assign take_stop = in_run & stop_exec;
  assign take_wake = in_halt & hit;
  // A restart still held keeps the core from dropping back to sleep
  assign go_sleep  = in_halt & ~hit & hold_s & ~restart_s;
  assign go_run    = in_wake & ~busreq_s;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (take_stop) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (take_wake) begin
          state_next = ST_WAKE;
        end else if (go_sleep) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // Interrupts are not seen while the core clock is off
        if (restart_s) begin
          state_next = ST_HALT;
        end
      end
      ST_WAKE: begin
        if (go_run) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Status register and taken level
  // ----------------------------------------------------------------
  logic [IPL_W-1:0] level_reg;
  wire  [SR_W-1:0]  sr_next;
  wire  [IPL_W-1:0] level_next;

  assign sr_next    = take_stop ? stop_operand : sr_reg;
  assign level_next = take_wake ? ipl_s : level_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sr_reg    <= SR_RESET;
      level_reg <= LEVEL_RESET;
    end else begin
      sr_reg    <= sr_next;
      level_reg <= level_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic clk_en_reg;
  logic stopped_reg;
  logic low_power_reg;
  logic resume_reg;

  wire clk_en_next;
  wire stopped_next;
  wire low_power_next;

  // The core clock is registered from the next state, so it changes on the same edge as the state, never mid-cycle
  assign clk_en_next    = (state_next != ST_SLEEP);
  assign stopped_next   = (state_next != ST_RUN);
  assign low_power_next = (state_next == ST_SLEEP);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_en_reg    <= 1'b1;
      stopped_reg   <= 1'b0;
      low_power_reg <= 1'b0;
      resume_reg    <= 1'b0;
    end else begin
      clk_en_reg    <= clk_en_next;
      stopped_reg   <= stopped_next;
      low_power_reg <= low_power_next;
      resume_reg    <= go_run;
    end
  end

  assign status_register = sr_reg;
  assign wake_level      = level_reg;
  assign core_clk_en     = clk_en_reg;
  assign stopped         = stopped_reg;
  assign low_power       = low_power_reg;
  assign exec_resume     = resume_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_stop_taken;
    in_run && stop_exec;
  endsequence

  sequence s_restart_seen;
    in_sleep ##0 restart_s;
  endsequence

  sequence s_blocked;
    in_wake && busreq_s;
  endsequence

  property p_stop_loads_sr;
    s_stop_taken |=> (sr_reg == $past(stop_operand)) && in_halt ##1 stopped;
  endproperty
  a_stop_loads_sr: assert property (p_stop_loads_sr)
    else $error("stop did not load the status register");

  property p_stay_stopped;
    (in_halt && !hit) |=> !in_run && !in_wake;
  endproperty
  a_stay_stopped: assert property (p_stay_stopped)
    else $error("left the stopped state without a qualifying level");

  property p_wake_level;
    (in_halt && hit) |=> in_wake && (level_reg == $past(ipl_s));
  endproperty
  a_wake_level: assert property (p_wake_level)
    else $error("qualifying level did not end the stopped state");

  property p_sleep_holds;
    (in_sleep && !restart_s) |=> in_sleep && !core_clk_en;
  endproperty
  a_sleep_holds: assert property (p_sleep_holds)
    else $error("sleep ended without a restart request");

  property p_restart_clock;
    s_restart_seen |=> in_halt && core_clk_en && !low_power;
  endproperty
  a_restart_clock: assert property (p_restart_clock)
    else $error("core clock did not start after restart");

  property p_bus_blocks;
    s_blocked |=> in_wake && !exec_resume;
  endproperty
  a_bus_blocks: assert property (p_bus_blocks)
    else $error("execution resumed while bus request held");

  property p_resume_pulse;
    (in_wake && !busreq_s) |=> exec_resume && in_run && !stopped ##1 !exec_resume;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse)
    else $error("resume pulse missing or too long");

endmodule

/* File: include/lp_pkg.sv */
// Purpose: Shared constants and types for the stop/sleep/wake sequencer
// Assumes: One system clock, asynchronous active-high reset
// Notes:   Widths, the mask field position and the status, level and sync reset values are collected here
package lp_pkg;

  // ----------------------------------------------------------------
  // Widths and field layout
  // ----------------------------------------------------------------
  localparam int SR_W     = 16;
  localparam int IPL_W    = 3;
  localparam int MASK_LSB = 8;
  localparam int SYNC_W   = IPL_W + 3;

  // ----------------------------------------------------------------
  // Values after reset and fixed codes
  // ----------------------------------------------------------------
  localparam logic [SR_W-1:0]  SR_RESET    = 16'h0000;
  localparam logic [IPL_W-1:0] LEVEL_RESET = 3'h0;
  localparam logic [IPL_W-1:0] NMI_LEVEL   = 3'h7;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HALT  = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE  = 2'b11
  } lp_state_t;

endpackage

/* File: include/wake_if.sv */
// Purpose: Carries the interrupt level and mask to the wake comparator
// Assumes: Both ends sit on clk_sys
// Notes:   Purely combinational group of signals
interface wake_if;
  import lp_pkg::*;

  logic [IPL_W-1:0] level;
  logic [IPL_W-1:0] mask;
  logic             hit;

  modport core (output level, output mask, input hit);
  modport cmp  (input level, input mask, output hit);
endinterface

/* File: rtl/mask_compare.sv */
// Purpose: Decides whether an interrupt level ends the stopped state
// Assumes: Level and mask already synchronised to clk_sys
// Notes:   The top level always passes, whatever the mask
module mask_compare
  import lp_pkg::*;
(
  // Level and mask in, decision out
  wake_if.cmp w
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  wire above_mask;
  wire top_level;

  assign above_mask = (w.level > w.mask);
  assign top_level  = (w.level == NMI_LEVEL);
  assign w.hit      = above_mask | top_level;

endmodule

/* File: testbench/glue_model.sv */
// Purpose: Glue that stops, restarts and polls for the core
// Assumes: Pins change on the falling edge of clk_sys
// Notes:   Clock settling is a fixed count, not measured
module glue_model
  import lp_pkg::*;
#(
  parameter int SETTLE = 6
)(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Bench commands
  input  wire logic             lp_write,
  input  wire logic [IPL_W-1:0] level_req,
  input  wire logic             br_req,
  // Core state
  input  wire logic             low_power,
  input  wire logic             core_clk_en,
  // Pins to the core
  output logic                  clock_hold,
  output logic                  restart_req,
  output logic      [IPL_W-1:0] buffered_interrupt_priority,
  output logic                  bus_request_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int settle_cnt;
  // Falling-edge launch leaves half a period of setup
  always @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      clock_hold <= 1'b0;
      restart_req <= 1'b0;
      buffered_interrupt_priority <= 3'h0;
      bus_request_in <= 1'b0;
      settle_cnt <= 0;
    end else begin
      buffered_interrupt_priority <= level_req;
      bus_request_in <= br_req;
      if (lp_write) begin
        clock_hold <= 1'b1;
      end
      // Only a level on the polled lines starts the clock again
      if (low_power && !restart_req && (buffered_interrupt_priority != 3'h0)) begin
        settle_cnt <= settle_cnt + 1;
      end else begin
        settle_cnt <= 0;
      end
      if (settle_cnt == SETTLE) begin
        restart_req <= 1'b1;
      end
      if (restart_req && core_clk_en) begin
        restart_req <= 1'b0;
        clock_hold <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/low_power_clock_stop_wake_tb.sv */
// Purpose: Self-checking bench for stop, sleep and wake sequencing
// Assumes: Inputs change on the falling edge, outputs read there too
// Notes:   Sleep, wake and resume latencies are checked with bounded waits; the stop is checked at exact counts
module low_power_clock_stop_wake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst, stop_exec, lp_write, br_req, clock_hold, restart_req, bus_request_in;
  logic [SR_W-1:0] stop_operand, status_register;
  logic [IPL_W-1:0] level_req, buffered_interrupt_priority, wake_level;
  logic core_clk_en, stopped, low_power, exec_resume;
  int failures = 0;
  int checked = 0;
  always #50 clk_sys = ~clk_sys;
  low_power_clock_stop_wake dut_u (.clk_sys(clk_sys), .rst(rst), .stop_exec(stop_exec),
    .stop_operand(stop_operand), .buffered_interrupt_priority(buffered_interrupt_priority),
    .clock_hold(clock_hold), .restart_req(restart_req), .bus_request_in(bus_request_in),
    .status_register(status_register), .wake_level(wake_level), .core_clk_en(core_clk_en),
    .stopped(stopped), .low_power(low_power), .exec_resume(exec_resume));
  glue_model glue_u (.clk_sys(clk_sys), .rst(rst), .lp_write(lp_write),
    .level_req(level_req), .br_req(br_req), .low_power(low_power),
    .core_clk_en(core_clk_en), .clock_hold(clock_hold), .restart_req(restart_req),
    .buffered_interrupt_priority(buffered_interrupt_priority),
    .bus_request_in(bus_request_in));
  // ----------------------------------------------------------------
  // Compare and wait helpers
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t value %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t flag %b, want %b", $time, got, exp);
    end
  endtask
  // Bounded wait: 0 low_power, 1 core_clk_en, 2 exec_resume
  task automatic wait_sig(input int sel, input logic want);
    logic v;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      v = (sel == 0) ? low_power : (sel == 1) ? core_clk_en : exec_resume;
      if (v === want) return;
    end
    chk_bit(~want, want);
  endtask
  task automatic do_stop(input logic [15:0] op);
    @(negedge clk_sys);
    stop_exec <= 1'b1;
    stop_operand <= op;
    @(negedge clk_sys);
    stop_exec <= 1'b0;
    chk_val(status_register, op);
    @(negedge clk_sys);
    chk_bit(stopped, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_val(status_register, 16'h0000);
    chk_val(16'(wake_level), 16'h0000);
    chk_bit(core_clk_en, 1'b1);
    chk_bit(stopped | low_power | exec_resume, 1'b0);
  endtask
  task automatic t_refuse();
    do_stop(16'h2000);
    stop_exec <= 1'b1;
    stop_operand <= 16'h0500;
    @(negedge clk_sys);
    stop_exec <= 1'b0;
    repeat (5) @(negedge clk_sys);
    chk_val(status_register, 16'h2000);
    chk_bit(stopped, 1'b1);
    level_req <= 3'h1;
    wait_sig(2, 1'b1);
    chk_val(16'(wake_level), 16'h0001);
    level_req <= 3'h0;
    // Let the cleared level pass the synchroniser before the next stop
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic t_sleep_wake();
    do_stop(16'h2000);
    br_req <= 1'b1;
    lp_write <= 1'b1;
    @(negedge clk_sys);
    lp_write <= 1'b0;
    wait_sig(0, 1'b1);
    chk_bit(core_clk_en, 1'b0);
    level_req <= 3'h3;
    repeat (3) @(negedge clk_sys);
    chk_bit(low_power, 1'b1);
    wait_sig(1, 1'b1);
    chk_bit(low_power, 1'b0);
    repeat (6) @(negedge clk_sys);
    chk_val(16'(wake_level), 16'h0003);
    chk_bit(stopped, 1'b1);
    br_req <= 1'b0;
    wait_sig(2, 1'b1);
    @(negedge clk_sys);
    chk_bit(exec_resume, 1'b0);
    chk_bit(stopped, 1'b0);
    level_req <= 3'h0;
    repeat (3) @(negedge clk_sys);
  endtask
  // A level at or below the mask must not wake; one above it, or the top level, must
  task automatic t_mask(input logic [15:0] op, input logic [2:0] lo, input logic [2:0] hi);
    do_stop(op);
    level_req <= lo;
    repeat (6) @(negedge clk_sys);
    chk_bit(stopped, 1'b1);
    level_req <= hi;
    wait_sig(2, 1'b1);
    chk_val(16'(wake_level), 16'(hi));
    level_req <= 3'h0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    $display("unexpected %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    stop_exec = 1'b0;
    stop_operand = 16'h0000;
    lp_write = 1'b0;
    level_req = 3'h0;
    br_req = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_refuse();
    t_sleep_wake();
    t_mask(16'h2300, 3'h3, 3'h4);
    t_mask(16'h2700, 3'h6, 3'h7);
    wrap_up();
  end
endmodule
